// File: bench/bmx_slave_model.sv
// Purpose: behavioural slave behind one matrix slave port
// Assumes: bench stall input holds ready off to make slow answers
// Notes:   idle data is the inverse of the last answer
`timescale 1ns/1ns
module bmx_slave_model
  import bmx_pkg::*;
#(
  parameter int ID = 0
)(
  input  wire logic     core_clk,
  input  wire logic     stall,
  input  wire bmx_req_s s_req,
  output bmx_rsp_s      s_rsp
);
  logic [DW-1:0] last_r;
  logic [DW-1:0] data;
  // data carries the slave number so a misrouted beat shows up
  assign data = s_req.addr ^ {8{1'b0, ID[2:0]}};
  always_comb begin
    s_rsp.ready = s_req.req & ~stall;
    s_rsp.err   = 1'b0;
    s_rsp.rdata = s_req.req ? data : ~last_r;
  end
  always_ff @(posedge core_clk) begin
    if (s_req.req) begin
      last_r <= data;
    end
  end
endmodule

// File: bench/test_multi_master_bus_matrix.sv
// Purpose: self-checking bench for the five by five bus matrix
// Assumes: single beats and short bursts, inputs driven at the falling edge
// Notes:   routing model kept in integers beside the design
`timescale 1ns/1ns
module test_multi_master_bus_matrix
  import bmx_pkg::*;
;
  logic         core_clk, reset, boot_select_pin, boot, boot_from_rom, rnd;
  logic [1:0]   remap_set, remap_clr, remap, remap_state;
  logic [4:0]   stall;
  logic [2:0]   ext_chip_sel;
  logic [2:0]   s_master [NS];
  bmx_arb_cfg_s arb_cfg [NS];
  bmx_req_s     m_req [NM];
  bmx_rsp_s     m_rsp [NM];
  bmx_req_s     s_req [NS];
  bmx_rsp_s     s_rsp [NS];
  int           n_mismatch, samples_checked;

  bmx_matrix u_dut (.core_clk, .reset, .boot_select_pin, .remap_set, .remap_clr, .arb_cfg,
    .m_req, .m_rsp, .s_req, .s_rsp, .s_master, .ext_chip_sel, .remap_state, .boot_from_rom);
  for (genvar i = 0; i < NS; i++) begin : g_sl
    bmx_slave_model #(.ID(i)) u_sl (.core_clk, .stall(stall[i]), .s_req(s_req[i]),
      .s_rsp(s_rsp[i]));
  end

  // ==========================================================
  // clock, stall and watchdog
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(negedge core_clk) stall <= rnd ? 5'($urandom) : 5'h0;
  initial begin
    #500_000;
    n_mismatch++;
    give_verdict();
  end

  // ==========================================================
  // model and tasks
  function automatic int exp_sl(int m, logic [31:0] a);
    if (a[31:28] >= 1 && a[31:28] <= 8) return 3;
    if (a[31:28] == 15) return 4;
    if (a[31:28] != 0) return 7;
    case (a[27:20])
      8'h00: return (m < 2 && remap[m]) ? 0 : (boot ? 1 : 3);
      8'h03: return 0;
      8'h04: return 1;
      8'h05, 8'h06: return 2;
      default: return 7;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input int m, input logic [31:0] a, input int nb = 1);
    int s;
    logic ok, er;
    logic [31:0] rd, ab;
    s = exp_sl(m, a);
    @(negedge core_clk);
    // a burst keeps req up between beats and marks only its final beat
    for (int b = 0; b < nb; b++) begin
      ab = a + 32'(4 * b);
      m_req[m] = '{1'b1, 1'b0, b == nb - 1, ab, $urandom};
      ok = 1'b0;
      for (int k = 0; k < 200 && ok !== 1'b1; k++) begin
        #20;
        ok = m_rsp[m].ready;
        er = m_rsp[m].err;
        rd = m_rsp[m].rdata;
        if (ok === 1'b1 && s != 7) chk(s_master[s], m);
        @(negedge core_clk);
      end
      chk(ok, 1);
      chk(er, s == 7);
      if (s != 7) chk(rd, ab ^ {8{1'b0, s[2:0]}});
    end
    m_req[m] = '0;
    if (s == 3) chk(ext_chip_sel, a[31:28] == 0 ? 0 : a[31:28] - 1);
  endtask

  task automatic do_reset(input logic pin);
    reset = 1'b1;
    boot_select_pin = pin;
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    boot = pin;
    remap = 2'b00;
    repeat (2) @(negedge core_clk);
    chk(boot_from_rom, pin);
    chk(remap_state, 0);
  endtask

  task automatic pulse(input logic [1:0] st, input logic [1:0] cl);
    @(negedge core_clk);
    remap_set = st;
    remap_clr = cl;
    @(negedge core_clk);
    remap_set = 2'b00;
    remap_clr = 2'b00;
    remap = (remap & ~cl) | st;
    @(negedge core_clk);
    chk(remap_state, remap);
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    int seed;
    logic [7:0] wins [6];
    wins = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
    remap_set = 2'b00;
    remap_clr = 2'b00;
    rnd = 1'b0;
    foreach (m_req[i]) m_req[i] = '0;
    foreach (arb_cfg[i]) arb_cfg[i] = '{BMX_DEF_LAST, 3'h0, 8'h04};
    seed = $urandom(32'h74c2_b411);
    do_reset(1'b1);
    for (int r = 0; r < 16; r++) acc(r % 5, {r[3:0], 28'($urandom)});
    for (int m = 0; m < 5; m++) foreach (wins[w]) acc(m, {4'h0, wins[w], 20'($urandom)});
    pulse(2'b01, 2'b00);
    for (int m = 0; m < 5; m++) acc(m, 32'($urandom) & 32'h000F_FFFF);
    pulse(2'b10, 2'b01);
    for (int m = 0; m < 3; m++) acc(m, 32'h0000_0010);
    pulse(2'b11, 2'b11);
    do_reset(1'b0);
    for (int m = 0; m < 5; m++) acc(m, 32'h0000_0100);
    rnd = 1'b1;
    for (int d = 0; d < 3; d++) begin
      foreach (arb_cfg[i]) arb_cfg[i] = '{bmx_def_e'(d), 3'($urandom_range(4)), 8'(d)};
      fork
        acc(1, 32'h0030_0100);
        acc(2, 32'h0030_0040, 3);
        acc(3, 32'h0030_0080);
        acc(4, 32'h0030_00c0);
      join
    end
    give_verdict();
  end
endmodule

// File: rtl/bmx_matrix.sv
// Purpose: five master, five slave bus matrix with per-master decode
// Assumes: slaves may hold ready low for wait states; masters hold req until ready
// Notes:   one beat per ready; last marks the final beat of a burst
// Behaviour
// - top four address bits choose one of sixteen 256 MB regions
// - regions one to eight go to external port, chip selects ascending
// - region zero goes to sram, rom, host interfaces or external boot, second stage splits it into one megabyte windows
// - region fifteen goes to the peripheral bridge slave
// - unassigned regions complete with an error, never reach a slave
// - five masters: instruction, data, peripheral dma, display, usb host
// - every master has its own decoder and bus
// - masters 0 and 1 choose internal boot, external boot or remapped slave at zero
// - each slave has its own arbiter
// - round-robin with none, last or fixed default master
// - a burst is broken after the programmed slot beat limit
// - boot select pin is sampled at the first clock after reset is released
// - after remap, sram replaces boot memory at address zero for the remapped master 0 or 1
// - five slaves: sram, rom, host interfaces, external port, peripherals
// - boot select high gives rom at zero, low gives external chip select zero
`timescale 1ns/1ns
module bmx_matrix
  import bmx_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         boot_select_pin,
  input  wire logic [1:0]   remap_set,
  input  wire logic [1:0]   remap_clr,
  input  wire bmx_arb_cfg_s arb_cfg [NS],
  input  wire bmx_req_s     m_req [NM],
  output bmx_rsp_s          m_rsp [NM],
  output bmx_req_s          s_req [NS],
  input  wire bmx_rsp_s     s_rsp [NS],
  output logic [2:0]        s_master [NS],
  output logic [2:0]        ext_chip_sel,
  output logic [1:0]        remap_state,
  output logic              boot_from_rom
);
  // ==========================================================================
  // decode
  function automatic logic [2:0] dec_slave(input logic [AW-1:0] a, input logic remapped,
                                           input logic boot_rom, input logic is_cpu);
    logic [3:0] rg;
    logic [7:0] win;
    rg  = a[REG_MSB:REG_LSB];
    win = a[WIN_MSB:WIN_LSB];
    dec_slave = SL_NONE;
    if (rg == REG_INT) begin
      case (win)
        WIN_BOOT: begin
          if (is_cpu && remapped)       dec_slave = SL_SRAM;
          else if (boot_rom)            dec_slave = SL_ROM;
          else                          dec_slave = SL_EXT;
        end
        WIN_SRAM: dec_slave = SL_SRAM;
        WIN_ROM:  dec_slave = SL_ROM;
        WIN_USBH, WIN_DISP: dec_slave = SL_HOSTIF;
        default:  dec_slave = SL_NONE;
      endcase
    end else if (rg >= REG_EXT_LO && rg <= REG_EXT_HI) begin
      dec_slave = SL_EXT;
    end else if (rg == REG_PERIPH) begin
      dec_slave = SL_PERIPH;
    end
  endfunction

  // ==========================================================================
  // boot strap and remap
  logic       boot_r, boot_nxt, strap_done_r, strap_done_nxt;
  logic [1:0] remap_r, remap_nxt;

  always_comb begin
    boot_nxt       = boot_r;
    strap_done_nxt = 1'b1;
    if (!strap_done_r) begin
      boot_nxt = boot_select_pin;
    end
    remap_nxt = (remap_r & ~remap_clr) | remap_set;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      boot_r       <= 1'b1;
      strap_done_r <= 1'b0;
      remap_r      <= 2'h0;
    end else begin
      boot_r       <= boot_nxt;
      strap_done_r <= strap_done_nxt;
      remap_r      <= remap_nxt;
    end
  end
  assign remap_state   = remap_r;
  assign boot_from_rom = boot_r;

  // ==========================================================================
  // per-master decoders
  logic [2:0]    m_tgt [NM];
  logic [2:0]    m_cs  [NM];
  // only the two cpu masters carry a remap bit; the others read zero
  logic [NM-1:0] remap_pad;
  assign remap_pad = {{(NM-2){1'b0}}, remap_r};
  genvar gm, gs;
  generate
    for (gm = 0; gm < NM; gm++) begin : g_dec
      always_comb begin
        m_tgt[gm] = dec_slave(m_req[gm].addr, remap_pad[gm], boot_r, gm < 2);
        if (m_req[gm].addr[REG_MSB:REG_LSB] == REG_INT)
          m_cs[gm] = CS_ZERO;
        else
          m_cs[gm] = 3'(m_req[gm].addr[REG_MSB:REG_LSB] - REG_EXT_LO);
      end
    end
  endgenerate

  // ==========================================================================
  // per-slave arbiters
  logic [2:0] own_r [NS], own_nxt [NS];
  logic [2:0] last_r [NS], last_nxt [NS];
  logic [7:0] slot_r [NS], slot_nxt [NS];
  logic       grant_ok [NS][NM];

  generate
    for (gs = 0; gs < NS; gs++) begin : g_arb
      logic [NM-1:0] want;
      logic [2:0]    pick;
      logic [2:0]    base;
      logic          beat, brk;
      always_comb begin
        for (int i = 0; i < NM; i++)
          want[i] = m_req[i].req && (m_tgt[i] == 3'(gs));
        // search after the current owner, so a finished owner goes to the back
        if (own_r[gs] != NO_MASTER)       base = own_r[gs];
        else if (last_r[gs] != NO_MASTER) base = last_r[gs];
        else                              base = 3'(NM - 1);
        pick = NO_MASTER;
        for (int k = NM; k >= 1; k--) begin
          if (want[(int'(base) + k) % NM])
            pick = 3'((int'(base) + k) % NM);
        end
        beat = (own_r[gs] != NO_MASTER) && want[own_r[gs]] && s_rsp[gs].ready;
        brk  = beat && (slot_r[gs] + 8'h01 >= arb_cfg[gs].slot_limit);
        own_nxt[gs]  = own_r[gs];
        last_nxt[gs] = last_r[gs];
        slot_nxt[gs] = beat ? slot_r[gs] + 8'h01 : slot_r[gs];
        // hand over only when the owner is idle or its last beat or slot-limit beat just finished
        if (own_r[gs] == NO_MASTER || !want[own_r[gs]] ||
            (beat && (m_req[own_r[gs]].last || brk))) begin
          slot_nxt[gs] = 8'h00;
          if (own_r[gs] != NO_MASTER) last_nxt[gs] = own_r[gs];
          if (pick != NO_MASTER && !(brk && pick == own_r[gs] && $countones(want) > 1))
            own_nxt[gs] = pick;
          else begin
            case (arb_cfg[gs].def_mode)
              BMX_DEF_LAST:  own_nxt[gs] = (own_r[gs] != NO_MASTER) ? own_r[gs] : last_r[gs];
              BMX_DEF_FIXED: own_nxt[gs] = arb_cfg[gs].fixed_master;
              default:       own_nxt[gs] = NO_MASTER;
            endcase
          end
        end
      end

      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          own_r[gs]  <= NO_MASTER;
          last_r[gs] <= NO_MASTER;
          slot_r[gs] <= 8'h00;
        end else begin
          own_r[gs]  <= own_nxt[gs];
          last_r[gs] <= last_nxt[gs];
          slot_r[gs] <= slot_nxt[gs];
        end
      end

      always_comb begin
        for (int i = 0; i < NM; i++)
          grant_ok[gs][i] = (own_r[gs] == 3'(i)) && want[i];
        s_req[gs] = '0;
        for (int i = 0; i < NM; i++)
          if (grant_ok[gs][i]) s_req[gs] = m_req[i];
      end
      assign s_master[gs] = own_r[gs];
    end
  endgenerate

  // ==========================================================================
  // responses and abort
  logic [2:0] cs_sel;
  always_comb begin
    cs_sel = CS_ZERO;
    for (int i = 0; i < NM; i++)
      if (grant_ok[SL_EXT][i]) cs_sel = m_cs[i];
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) ext_chip_sel <= CS_ZERO;
    else       ext_chip_sel <= cs_sel;
  end

  generate
    for (gm = 0; gm < NM; gm++) begin : g_rsp
      always_comb begin
        m_rsp[gm] = '0;
        if (m_req[gm].req && m_tgt[gm] == SL_NONE) begin
          m_rsp[gm].ready = 1'b1;
          m_rsp[gm].err   = 1'b1;
        end else begin
          for (int s = 0; s < NS; s++)
            if (grant_ok[s][gm]) m_rsp[gm] = s_rsp[s];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // checks
  a_abort_err: assert property (@(posedge core_clk) disable iff (reset)
    m_req[2].req && m_req[2].addr[REG_MSB:REG_LSB] inside {[4'h9:4'hE]} |->
      m_rsp[2].err && m_rsp[2].ready && !grant_ok[SL_EXT][2])
    else $error("unmapped region not aborted");
  a_remap_sram: assert property (@(posedge core_clk) disable iff (reset)
    remap_r[1] && m_req[1].req && m_req[1].addr[REG_MSB:WIN_LSB] == 12'h000 |->
      m_tgt[1] == SL_SRAM)
    else $error("remapped zero not sram");
  a_boot_rom: assert property (@(posedge core_clk) disable iff (reset)
    !remap_r[0] && m_req[0].req && m_req[0].addr[REG_MSB:WIN_LSB] == 12'h000 |->
      m_tgt[0] == (boot_r ? SL_ROM : SL_EXT))
    else $error("boot slave wrong");
  a_ext_region: assert property (@(posedge core_clk) disable iff (reset)
    m_req[3].req && m_req[3].addr[REG_MSB:REG_LSB] == 4'h8 |-> m_tgt[3] == SL_EXT)
    else $error("region eight not external");
  a_periph_reg: assert property (@(posedge core_clk) disable iff (reset)
    m_req[0].req && m_req[0].addr[REG_MSB:REG_LSB] == 4'hF |-> m_tgt[0] == SL_PERIPH)
    else $error("region fifteen not peripheral");
  a_dma_noremap: assert property (@(posedge core_clk) disable iff (reset)
    m_req[2].req && m_req[2].addr[REG_MSB:WIN_LSB] == 12'h000 |-> m_tgt[2] != SL_SRAM)
    else $error("dma master remapped");
  a_strap_hold: assert property (@(posedge core_clk) disable iff (reset)
    strap_done_r |=> $stable(boot_r))
    else $error("boot strap changed after reset");
  a_hold_beat: assert property (@(posedge core_clk) disable iff (reset)
    s_req[SL_SRAM].req && !s_rsp[SL_SRAM].ready |=> $stable(own_r[SL_SRAM]))
    else $error("grant moved mid beat");
  a_slot_cap: assert property (@(posedge core_clk) disable iff (reset)
    arb_cfg[SL_SRAM].slot_limit != 8'h00 |-> slot_r[SL_SRAM] < arb_cfg[SL_SRAM].slot_limit)
    else $error("slot limit exceeded");
  a_fixed_def: assert property (@(posedge core_clk) disable iff (reset)
    arb_cfg[SL_ROM].def_mode == BMX_DEF_FIXED && !(|g_arb[SL_ROM].want) |=>
      own_r[SL_ROM] == $past(arb_cfg[SL_ROM].fixed_master))
    else $error("fixed default master missing");
  c_abort: cover property (@(posedge core_clk) m_rsp[1].err);
  c_remap: cover property (@(posedge core_clk) remap_r == 2'h3);
  c_brk:   cover property (@(posedge core_clk) g_arb[SL_SRAM].brk);
  c_share: cover property (@(posedge core_clk) $countones(g_arb[SL_SRAM].want) > 1);
endmodule

// File: rtl/bmx_pkg.sv
// Purpose: shared constants and carriers for the five by five bus matrix
// Assumes: simple request/ready/error bus per master and per slave
// Notes:   region and window figures are fixed by the address map
package bmx_pkg;
  localparam int NM          = 5;
  localparam int NS          = 5;
  localparam int AW          = 32;
  localparam int DW          = 32;
  localparam int REG_MSB     = 31;
  localparam int REG_LSB     = 28;
  localparam int WIN_MSB     = 27;
  localparam int WIN_LSB     = 20;
  localparam int SUB_MSB     = 19;
  localparam int SUB_LSB     = 16;
  localparam logic [3:0] REG_INT = 4'h0;
  localparam logic [3:0] REG_EXT_LO = 4'h1;
  localparam logic [3:0] REG_EXT_HI = 4'h8;
  localparam logic [3:0] REG_PERIPH = 4'hF;
  // second stage inside region zero, one megabyte windows
  localparam logic [7:0] WIN_BOOT = 8'h00;
  localparam logic [7:0] WIN_SRAM = 8'h03;
  localparam logic [7:0] WIN_ROM  = 8'h04;
  localparam logic [7:0] WIN_USBH = 8'h05;
  localparam logic [7:0] WIN_DISP = 8'h06;
  localparam logic [2:0] SL_SRAM  = 3'h0;
  localparam logic [2:0] SL_ROM   = 3'h1;
  localparam logic [2:0] SL_HOSTIF = 3'h2;
  localparam logic [2:0] SL_EXT   = 3'h3;
  localparam logic [2:0] SL_PERIPH = 3'h4;
  localparam logic [2:0] SL_NONE  = 3'h7;
  localparam logic [2:0] CS_ZERO  = 3'h0;
  localparam logic [2:0] NO_MASTER = 3'h7;
  localparam logic [7:0] SLOT_RST = 8'h10;

  typedef enum logic [1:0] {
    BMX_DEF_NONE  = 2'h0,
    BMX_DEF_LAST  = 2'h1,
    BMX_DEF_FIXED = 2'h2
  } bmx_def_e;

  typedef struct packed {
    logic          req;
    logic          wr;
    logic          last;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } bmx_req_s;

  typedef struct packed {
    logic          ready;
    logic          err;
    logic [DW-1:0] rdata;
  } bmx_rsp_s;

  typedef struct packed {
    bmx_def_e   def_mode;
    logic [2:0] fixed_master;
    logic [7:0] slot_limit;
  } bmx_arb_cfg_s;
endpackage
